// File: hdl/spimsc_core.sv
// serial master/slave port core with double-buffered receive
`timescale 1ns/1ps
module spimsc_core (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic port_enable_i,
   input wire logic ctrl1_wr_i,
   input wire logic master_select_i,
   input wire logic clock_phase_sel_i,
   input wire logic clock_polarity_sel_i,
   input wire logic pin_config_bit_i,
   input wire logic bidir_out_enable_i,
   input wire logic fault_detect_enable_i,
   input wire logic select_output_enable_i,
   input wire logic port_irq_enable_i,
   input wire logic rate_select_2_i,
   input wire logic rate_select_1_i,
   input wire logic rate_select_0_i,
   input wire logic rate_preselect_2_i,
   input wire logic rate_preselect_1_i,
   input wire logic rate_preselect_0_i,
   input wire logic status_rd_i,
   input wire logic data_rd_i,
   input wire logic data_wr_i,
   input wire logic [7:0] data_wr_data_i,
   output logic [7:0] serial_data_reg_o,
   output logic transfer_done_flag_o,
   output logic tx_empty_flag_o,
   output logic mode_fault_flag_o,
   output logic master_select_o,
   output logic irq_o,
   input wire logic link_sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic ss_n_i,
   output logic ss_n_o,
   output logic ss_n_oe_o,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o
);
   // ****************************************************************
   // synchronisers into the bus clock
   // ****************************************************************
   logic [spimsc_pkg::SYNC_N-1:0] sy_raw;
   logic [spimsc_pkg::SYNC_N-1:0] sy1_q;
   logic [spimsc_pkg::SYNC_N-1:0] sy2_q;
   logic done_tgl_q;
   assign sy_raw = {done_tgl_q, miso_i, mosi_i, ss_n_i};
   genvar gi;
   generate
      for (gi = 0; gi < spimsc_pkg::SYNC_N; gi++) begin : g_sync
         always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               sy1_q[gi] <= (gi == spimsc_pkg::SY_SS);
               sy2_q[gi] <= (gi == spimsc_pkg::SY_SS);
            end else begin
               sy1_q[gi] <= sy_raw[gi];
               sy2_q[gi] <= sy1_q[gi];
            end
         end
      end
   endgenerate
   logic ss_s;
   logic done_s_q;
   assign ss_s = sy2_q[spimsc_pkg::SY_SS];
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         done_s_q <= 1'b0;
      end else begin
         done_s_q <= sy2_q[spimsc_pkg::SY_DONE];
      end
   end
   // ****************************************************************
   // mode control and mode fault
   // ****************************************************************
   logic master_q;
   logic fault_q;
   logic fault_armed_q;
   logic fault_evt;
   logic ss_is_out;
   assign ss_is_out = master_q & fault_detect_enable_i
      & select_output_enable_i;
   assign fault_evt = port_enable_i & master_q & fault_detect_enable_i
      & ~select_output_enable_i & ~ss_s;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         master_q <= 1'b0;
      end else if (fault_evt) begin
         master_q <= 1'b0;
      end else if (ctrl1_wr_i) begin
         master_q <= master_select_i;
      end
   end
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fault_q <= 1'b0;
         fault_armed_q <= 1'b0;
      end else begin
         if (status_rd_i & fault_q) begin
            fault_armed_q <= 1'b1;
         end else if (ctrl1_wr_i) begin
            fault_armed_q <= 1'b0;
         end
         if (fault_evt) begin
            fault_q <= 1'b1;
         end else if (ctrl1_wr_i & fault_armed_q) begin
            fault_q <= 1'b0;
         end
      end
   end
   // ****************************************************************
   // transmit buffer
   // ****************************************************************
   logic [7:0] tx_buf_q;
   logic tx_full_q;
   logic tx_armed_q;
   logic tx_take;
   logic tx_acc;
   assign tx_acc = data_wr_i & ~tx_full_q & tx_armed_q;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_buf_q <= spimsc_pkg::DATA_RST;
         tx_full_q <= 1'b0;
         tx_armed_q <= 1'b0;
      end else begin
         if (status_rd_i & ~tx_full_q) begin
            tx_armed_q <= 1'b1;
         end else if (data_wr_i) begin
            tx_armed_q <= 1'b0;
         end
         if (tx_acc) begin
            tx_buf_q <= data_wr_data_i;
         end
         if (tx_acc) begin
            tx_full_q <= 1'b1;
         end else if (tx_take | ~port_enable_i) begin
            tx_full_q <= 1'b0;
         end
      end
   end
   // ****************************************************************
   // master engine and baud generator
   // ****************************************************************
   spimsc_pkg::spimsc_mstate_type m_state_q;
   logic [spimsc_pkg::HALF_W-1:0] half_cnt_q;
   logic [spimsc_pkg::HALF_W-1:0] half_len;
   logic [spimsc_pkg::EDGE_W-1:0] edge_q;
   logic [7:0] m_sh_q;
   logic m_out_q;
   logic m_sck_q;
   logic m_done;
   logic m_din;
   logic m_run_en;
   logic half_end;
   logic samp_edge;
   logic [2:0] rate;
   logic [3:0] pre;
   assign rate = {rate_select_2_i, rate_select_1_i, rate_select_0_i};
   assign pre = {1'b0, rate_preselect_2_i, rate_preselect_1_i,
                 rate_preselect_0_i} + 4'h1;
   // half period is pre << rate bus cycles, pre being the preselect plus one
   assign half_len = spimsc_pkg::HALF_W'({7'h00, pre} << rate);
   assign half_end = (half_cnt_q == half_len - 11'h001);
   assign m_run_en = port_enable_i & master_q;
   assign m_din = pin_config_bit_i ? sy2_q[spimsc_pkg::SY_MOSI]
                                   : sy2_q[spimsc_pkg::SY_MISO];
   // edge_q holds number of the edge about to occur, from one
   assign samp_edge = edge_q[0] ^ clock_phase_sel_i;
   assign m_done = (m_state_q == spimsc_pkg::M_RUN) & half_end
      & (edge_q == spimsc_pkg::EDGE_LAST);
   assign tx_take = m_run_en ? ((m_state_q == spimsc_pkg::M_IDLE)
      & tx_full_q) : (ss_s & tx_full_q);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         m_state_q <= spimsc_pkg::M_IDLE;
         half_cnt_q <= '0;
         edge_q <= '0;
      end else if (~m_run_en) begin
         m_state_q <= spimsc_pkg::M_IDLE;
         half_cnt_q <= '0;
         edge_q <= '0;
      end else begin
         half_cnt_q <= (half_end | m_state_q == spimsc_pkg::M_IDLE)
            ? '0 : half_cnt_q + 11'h001;
         unique case (m_state_q)
            spimsc_pkg::M_IDLE: begin
               edge_q <= 5'h01;
               if (tx_full_q) begin
                  m_state_q <= spimsc_pkg::M_LEAD;
               end
            end
            spimsc_pkg::M_LEAD: begin
               if (half_end) begin
                  m_state_q <= spimsc_pkg::M_RUN;
               end
            end
            spimsc_pkg::M_RUN: begin
               if (half_end) begin
                  edge_q <= edge_q + 5'h01;
                  if (edge_q == spimsc_pkg::EDGE_LAST) begin
                     m_state_q <= spimsc_pkg::M_IDLE;
                  end
               end
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         m_sh_q <= spimsc_pkg::DATA_RST;
         m_out_q <= 1'b0;
         m_sck_q <= 1'b0;
      end else if (m_run_en & (m_state_q == spimsc_pkg::M_IDLE)) begin
         m_sck_q <= 1'b0;
         if (tx_full_q) begin
            m_sh_q <= tx_buf_q;
            m_out_q <= tx_buf_q[7];
         end
      end else if ((m_state_q == spimsc_pkg::M_RUN) & half_end) begin
         m_sck_q <= ~m_sck_q;
         if (samp_edge) begin
            m_sh_q <= {m_sh_q[6:0], m_din};
         end else begin
            m_out_q <= m_sh_q[7];
         end
      end
   end
   // ****************************************************************
   // slave shifter on the link clock
   // ****************************************************************
   logic [7:0] s_tx_q;
   logic [7:0] s_sh_q;
   logic [7:0] s_cur;
   logic [7:0] s_rx_q;
   logic [2:0] s_cnt_q;
   logic s_out_q;
   logic s_started_q;
   logic s_din;
   logic s_clk;
   logic s_rst;
   // sampling always lands on the rising edge of s_clk
   assign s_clk = link_sck_i ^ clock_polarity_sel_i
      ^ clock_phase_sel_i;
   // frame select high holds the slave logic idle
   assign s_rst = sys_rst_i | ss_n_i | ~port_enable_i | master_q;
   assign s_din = pin_config_bit_i ? miso_i : mosi_i;
   assign s_cur = (s_cnt_q == 3'h0) ? s_tx_q : s_sh_q;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_tx_q <= spimsc_pkg::DATA_RST;
      end else if (~m_run_en & ss_s & tx_full_q) begin
         s_tx_q <= tx_buf_q; // stable while frame select is low
      end
   end
   always_ff @(posedge s_clk or posedge s_rst) begin
      if (s_rst) begin
         s_sh_q <= spimsc_pkg::DATA_RST;
         s_cnt_q <= 3'h0;
      end else begin
         s_sh_q <= {s_cur[6:0], s_din};
         s_cnt_q <= s_cnt_q + 3'h1;
      end
   end
   always_ff @(posedge s_clk or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_rx_q <= spimsc_pkg::DATA_RST;
         done_tgl_q <= 1'b0;
      end else if (~ss_n_i & (s_cnt_q == spimsc_pkg::BIT_LAST)) begin
         s_rx_q <= {s_cur[6:0], s_din};
         done_tgl_q <= ~done_tgl_q;
      end
   end
   always_ff @(negedge s_clk or posedge s_rst) begin
      if (s_rst) begin
         s_out_q <= 1'b0;
         s_started_q <= 1'b0;
      end else begin
         s_out_q <= (s_cnt_q == 3'h0) ? s_tx_q[7] : s_sh_q[7];
         s_started_q <= 1'b1;
      end
   end
   // ****************************************************************
   // receive buffer and flags
   // ****************************************************************
   logic s_done;
   logic xfer_done;
   logic done_q;
   logic done_armed_q;
   logic [7:0] rx_q;
   logic [7:0] rd_q;
   logic irq_q;
   assign s_done = done_s_q ^ sy2_q[spimsc_pkg::SY_DONE];
   assign xfer_done = m_done | (s_done & ~m_run_en);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_q <= spimsc_pkg::DATA_RST;
         done_q <= 1'b0;
         done_armed_q <= 1'b0;
      end else begin
         // phase set: last sample lands on the final edge itself
         if (xfer_done & ~done_q) begin
            rx_q <= m_done ? (samp_edge ? {m_sh_q[6:0], m_din} : m_sh_q)
               : s_rx_q;
         end
         if (status_rd_i & done_q) begin
            done_armed_q <= 1'b1;
         end else if (data_rd_i) begin
            done_armed_q <= 1'b0;
         end
         if (xfer_done) begin
            done_q <= 1'b1;
         end else if (data_rd_i & done_armed_q) begin
            done_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_q <= spimsc_pkg::DATA_RST;
         irq_q <= 1'b0;
      end else begin
         rd_q <= rx_q;
         irq_q <= port_irq_enable_i & (fault_q | done_q);
      end
   end
   // ****************************************************************
   // pin drivers
   // ****************************************************************
   logic sck_q;
   logic sck_oe_q;
   logic ss_q;
   logic ss_oe_q;
   logic mosi_q;
   logic mosi_oe_q;
   logic miso_oe_q;
   logic m_end_q;
   logic s_sel;
   assign s_sel = port_enable_i & ~master_q & ~ss_s;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sck_q <= 1'b0;
         sck_oe_q <= 1'b0;
         ss_q <= 1'b1;
         ss_oe_q <= 1'b0;
         mosi_q <= 1'b0;
         mosi_oe_q <= 1'b0;
         miso_oe_q <= 1'b0;
         m_end_q <= 1'b0;
      end else begin
         m_end_q <= m_done;
         sck_q <= m_sck_q ^ clock_polarity_sel_i;
         sck_oe_q <= m_run_en & ~fault_evt;
         // stays low past the last clock edge on the pin
         ss_q <= (m_state_q == spimsc_pkg::M_IDLE) & ~m_end_q;
         ss_oe_q <= port_enable_i & ss_is_out;
         mosi_q <= m_out_q;
         mosi_oe_q <= m_run_en & ~fault_evt
            & (~pin_config_bit_i | bidir_out_enable_i);
         miso_oe_q <= s_sel
            & (~pin_config_bit_i | bidir_out_enable_i);
      end
   end
   assign sck_o = sck_q;
   assign sck_oe_o = sck_oe_q;
   assign ss_n_o = ss_q;
   assign ss_n_oe_o = ss_oe_q;
   assign mosi_o = mosi_q;
   assign mosi_oe_o = mosi_oe_q;
   // slave output must follow the link edge, so it bypasses the bus clock
   assign miso_o = s_started_q ? s_out_q : s_tx_q[7];
   assign miso_oe_o = miso_oe_q;
   assign serial_data_reg_o = rd_q;
   assign transfer_done_flag_o = done_q;
   assign tx_empty_flag_o = ~tx_full_q;
   assign mode_fault_flag_o = fault_q;
   assign master_select_o = master_q;
   assign irq_o = irq_q;
endmodule

// File: hdl/spimsc_pkg.sv
// constants for the serial master/slave port core
package spimsc_pkg;
   localparam int DATA_W = 8;
   localparam int HALF_W = 11;
   localparam int EDGE_W = 5;
   localparam logic [4:0] EDGE_LAST = 5'h10;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam int SYNC_N = 4;
   localparam int SY_SS = 0;
   localparam int SY_MOSI = 1;
   localparam int SY_MISO = 2;
   localparam int SY_DONE = 3;
   typedef enum logic [1:0] {
      M_IDLE,
      M_LEAD,
      M_RUN
   } spimsc_mstate_type;
endpackage

// File: tb/spi_master_slave_core_test.sv
// self-checking bench for the serial master/slave port core
`timescale 1ns/1ps
module spi_master_slave_core_test;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic port_enable_i, ctrl1_wr_i, master_select_i, clock_phase_sel_i;
   logic clock_polarity_sel_i, pin_config_bit_i, bidir_out_enable_i;
   logic fault_detect_enable_i, select_output_enable_i, port_irq_enable_i;
   logic rate_select_2_i, rate_select_1_i, rate_select_0_i;
   logic rate_preselect_2_i, rate_preselect_1_i, rate_preselect_0_i;
   logic status_rd_i, data_rd_i, data_wr_i;
   logic [7:0] data_wr_data_i, serial_data_reg_o, peer_tx, peer_rx, got;
   logic transfer_done_flag_o, tx_empty_flag_o, mode_fault_flag_o, irq_o;
   logic master_select_o, sck_o, sck_oe_o, ss_n_o, ss_n_oe_o;
   logic mosi_o, mosi_oe_o, miso_o, miso_oe_o;
   logic tb_sck, tb_ss, tb_mosi, peer_miso;
   wire logic link_sck_i, ss_n_i, mosi_i, miso_i;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h307b;
   int err_count = 0;
   int num_checks = 0;
   assign link_sck_i = sck_oe_o ? sck_o : tb_sck;
   assign ss_n_i = ss_n_oe_o ? ss_n_o : tb_ss;
   assign mosi_i = mosi_oe_o ? mosi_o : tb_mosi;
   assign miso_i = miso_oe_o ? miso_o : peer_miso;
   spimsc_core uut (.*);
   spimsc_peer u_peer (.sck_i(link_sck_i), .ss_n_i(ss_n_i), .mosi_i(mosi_i),
      .pol_i(clock_polarity_sel_i), .pha_i(clock_phase_sel_i),
      .tx_i(peer_tx), .miso_o(peer_miso), .rx_o(peer_rx));
   always #10 sys_clk_i = ~sys_clk_i;
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      if (err_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic pulse_status();
      @(posedge sys_clk_i) status_rd_i <= 1'b1;
      @(posedge sys_clk_i) status_rd_i <= 1'b0;
   endtask
   task automatic write_byte(logic [7:0] b);
      pulse_status();
      data_wr_i <= 1'b1;
      data_wr_data_i <= b;
      @(posedge sys_clk_i) data_wr_i <= 1'b0;
   endtask
   task automatic read_done();
      pulse_status();
      data_rd_i <= 1'b1;
      @(posedge sys_clk_i) data_rd_i <= 1'b0;
   endtask
   task automatic ctrl_write(logic ms);
      master_select_i <= ms;
      ctrl1_wr_i <= 1'b1;
      @(posedge sys_clk_i) ctrl1_wr_i <= 1'b0;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 3000 && transfer_done_flag_o !== 1'b1; i++)
         cyc(1);
      check("done_set", 8'(transfer_done_flag_o), 8'h01);
   endtask
   task automatic master_xfer(logic pol, logic pha);
      logic [7:0] tx;
      tx = rnd();
      peer_tx = rnd();
      exp_q.push_back(peer_tx);
      clock_polarity_sel_i <= pol;
      clock_phase_sel_i <= pha;
      {rate_preselect_2_i, rate_preselect_1_i, rate_preselect_0_i} <=
         {1'b0, seed[9:8] | 2'h1};
      {rate_select_2_i, rate_select_1_i, rate_select_0_i} <=
         {1'b0, seed[10], ~seed[10]};
      cyc(2);
      write_byte(tx);
      wait_done();
      cyc(4);
      check("peer_rx", peer_rx, tx);
      read_done();
   endtask
   task automatic slave_xfer();
      logic [7:0] tx, mb;
      tx = rnd();
      mb = rnd();
      write_byte(tx);
      exp_q.push_back(mb);
      cyc(6);
      #7;
      // clock toggles while unselected must be ignored
      repeat (4) #40 tb_sck = ~tb_sck;
      tb_ss = 1'b0;
      #120;
      for (int i = 7; i >= 0; i--) begin
         tb_mosi = mb[i];
         #80 got[i] = miso_i;
         tb_sck = 1'b1;
         #80 tb_sck = 1'b0;
      end
      #80 tb_ss = 1'b1;
      tb_mosi = ~tb_mosi;
      wait_done();
      cyc(4);
      check("slave_out", got, tx);
      read_done();
   endtask
   always @(posedge transfer_done_flag_o) begin
      cyc(2);
      #1;
      if (exp_q.size() == 0)
         check("rx_extra", 8'h00, 8'hff);
      else
         check("rx_data", serial_data_reg_o, exp_q.pop_front());
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {port_enable_i, ctrl1_wr_i, master_select_i, clock_phase_sel_i} = '0;
      {clock_polarity_sel_i, pin_config_bit_i, bidir_out_enable_i} = '0;
      {fault_detect_enable_i, select_output_enable_i, port_irq_enable_i} = '0;
      {rate_select_2_i, rate_select_1_i, rate_select_0_i} = '0;
      {rate_preselect_2_i, rate_preselect_1_i, rate_preselect_0_i} = '0;
      {status_rd_i, data_rd_i, data_wr_i, tb_sck, tb_mosi} = '0;
      data_wr_data_i = 8'h00;
      peer_tx = 8'h00;
      tb_ss = 1'b1;
      cyc(4);
      sys_rst_i <= 1'b0;
      got = {ss_n_o, tx_empty_flag_o, transfer_done_flag_o, mode_fault_flag_o,
         sck_oe_o, mosi_oe_o, ss_n_oe_o, irq_o};
      check("reset", got, 8'hc0);
      cyc(3);
      {port_enable_i, fault_detect_enable_i, select_output_enable_i} <= 3'h7;
      ctrl_write(1'b1);
      cyc(3);
      check("ss_oe", 8'(ss_n_oe_o), 8'h01);
      data_wr_i <= 1'b1;
      data_wr_data_i <= rnd();
      @(posedge sys_clk_i) data_wr_i <= 1'b0;
      cyc(3);
      check("tx_empty", 8'(tx_empty_flag_o), 8'h01);
      for (int m = 0; m < 4; m++)
         master_xfer(m[1], m[0]);
      {clock_polarity_sel_i, clock_phase_sel_i, select_output_enable_i} <= '0;
      ctrl_write(1'b0);
      cyc(3);
      slave_xfer();
      port_irq_enable_i <= 1'b1;
      ctrl_write(1'b1);
      cyc(3);
      #3 tb_ss = 1'b0;
      cyc(8);
      check("master", 8'(master_select_o), 8'h00);
      check("fault", 8'(mode_fault_flag_o), 8'h01);
      check("irq", 8'(irq_o), 8'h01);
      check("sck_oe", 8'(sck_oe_o), 8'h00);
      tb_ss <= 1'b1;
      cyc(4);
      pulse_status();
      ctrl_write(1'b0);
      cyc(3);
      check("fault_clr", 8'(mode_fault_flag_o), 8'h00);
      port_enable_i <= 1'b0;
      cyc(4);
      got = {4'h0, sck_oe_o, mosi_oe_o, miso_oe_o, ss_n_oe_o};
      check("pins_off", got, 8'h00);
      test_done();
   end
   initial begin
      #400000;
      check("watchdog", 8'h00, 8'h01);
      test_done();
   end
endmodule

// File: tb/spimsc_peer.sv
// behavioural far-side serial slave for master mode runs
`timescale 1ns/1ps
module spimsc_peer (
   input wire logic sck_i,
   input wire logic ss_n_i,
   input wire logic mosi_i,
   input wire logic pol_i,
   input wire logic pha_i,
   input wire logic [7:0] tx_i,
   output logic miso_o,
   output logic [7:0] rx_o
);
   int cnt = 0;
   initial miso_o = 1'b0;
   initial rx_o = 8'h00;
   always @(negedge ss_n_i) begin
      rx_o = 8'h00;
      cnt = pha_i ? 8 : 7;
      if (!pha_i)
         miso_o = tx_i[7];
   end
   // released line shows the inverse of its last value
   always @(posedge ss_n_i) miso_o = ~miso_o;
   always @(sck_i) begin
      if (!ss_n_i && ((sck_i != pol_i) != pha_i)) begin
         rx_o = {rx_o[6:0], mosi_i};
      end else if (!ss_n_i) begin
         cnt = cnt - 1;
         miso_o = (cnt >= 0) ? tx_i[cnt] : ~miso_o;
      end
   end
endmodule

// File: tb/spimsc_props.sv
// concurrent checks on the serial port core pins and flags
`timescale 1ns/1ps
module spimsc_props (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic port_enable_i,
   input wire logic ctrl1_wr_i,
   input wire logic clock_polarity_sel_i,
   input wire logic fault_detect_enable_i,
   input wire logic select_output_enable_i,
   input wire logic port_irq_enable_i,
   input wire logic rate_select_2_i,
   input wire logic rate_select_1_i,
   input wire logic rate_select_0_i,
   input wire logic rate_preselect_2_i,
   input wire logic rate_preselect_1_i,
   input wire logic rate_preselect_0_i,
   input wire logic status_rd_i,
   input wire logic data_rd_i,
   input wire logic transfer_done_flag_o,
   input wire logic mode_fault_flag_o,
   input wire logic master_select_o,
   input wire logic irq_o,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic ss_n_i,
   input wire logic ss_n_o,
   input wire logic ss_n_oe_o,
   input wire logic mosi_oe_o,
   input wire logic miso_oe_o
);
   logic sck_prev_q, seen_q, chg;
   logic [11:0] gap_q, half;
   assign chg = sck_o != sck_prev_q;
   assign half = (12'({rate_preselect_2_i, rate_preselect_1_i,
      rate_preselect_0_i}) + 12'h1) << {rate_select_2_i, rate_select_1_i,
      rate_select_0_i};
   // cycles since the last clock pin change, and whether an edge was seen in this frame
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sck_prev_q <= 1'b0;
         gap_q <= 12'h0;
         seen_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_o;
         gap_q <= chg ? 12'h0 : gap_q + 12'h1;
         seen_q <= !ss_n_o && (seen_q || chg);
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_fault;
      port_enable_i && master_select_o && fault_detect_enable_i &&
         !select_output_enable_i && $fell(ss_n_i);
   endsequence
   sequence s_done_read;
      status_rd_i && transfer_done_flag_o ##1 data_rd_i;
   endsequence
   sequence s_fault_ack;
      status_rd_i && mode_fault_flag_o ##1 ctrl1_wr_i;
   endsequence
   a_off_no_drive: assert property ((!port_enable_i) [*3] |->
      !(sck_oe_o || mosi_oe_o || miso_oe_o || ss_n_oe_o))
      else $error("pin driven while port disabled");
   a_fault_drops_pins: assert property (s_fault |-> ##[1:6]
      (!sck_oe_o && !mosi_oe_o && !master_select_o && mode_fault_flag_o))
      else $error("mode fault not handled");
   a_fault_irq_req: assert property ($rose(mode_fault_flag_o) &&
      port_irq_enable_i |-> ##[0:2] irq_o) else $error("no fault irq");
   a_ss_out_gate: assert property ((!port_enable_i || !master_select_o ||
      !select_output_enable_i || !fault_detect_enable_i) [*3] |-> !ss_n_oe_o)
      else $error("select driven without both enables");
   a_ss_low_edges: assert property (sck_oe_o && ss_n_oe_o && chg &&
      clock_polarity_sel_i == $past(clock_polarity_sel_i, 2) |-> !ss_n_o)
      else $error("clock edge with select high");
   a_sck_half_period: assert property (sck_oe_o && ss_n_oe_o && chg &&
      seen_q |-> gap_q == half - 12'h1) else $error("wrong clock half period");
   a_idle_sck_level: assert property ($stable(clock_polarity_sel_i) [*3]
      ##0 (sck_oe_o && ss_n_oe_o && ss_n_o) |-> sck_o == clock_polarity_sel_i)
      else $error("idle clock level differs from polarity");
   a_done_read_clear: assert property (s_done_read |->
      ##[1:2] !transfer_done_flag_o) else $error("done flag not cleared");
   a_fault_ack_clear: assert property (s_fault_ack |->
      ##[1:2] !mode_fault_flag_o) else $error("fault flag not cleared");
   a_slave_miso_off: assert property ((!master_select_o && ss_n_i) [*4]
      |-> !miso_oe_o) else $error("unselected slave drives data out");
endmodule
bind spimsc_core spimsc_props u_props (.*);
